// [dv/dhwrc_ctrl_assertions.sv]
`timescale 1ns/1ns
module dhwrc_ctrl_checker (
  // Clock and reset
  input wire logic                   pclk,
  input wire logic                   presetn,
  // APB
  input wire logic [31:0]            paddr,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [31:0]            pwdata,
  input wire logic                   pready,
  // Access port and pins
  input wire logic                   acc_valid,
  input wire dhwrc_pkg::dhwrc_req_t  acc_req,
  input wire logic                   acc_ready,
  input wire logic                   acc_done,
  input wire dhwrc_pkg::dhwrc_pins_t dram_o
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // Register shadows and row high counters
  // ----
  logic [7:0] cfg_q, frc_q;
  logic       cur16_q, short_q;
  logic [3:0] row_p_q;
  logic [2:0] hi_q [4];
  wire        wr   = psel && penable && pready && pwrite;
  wire        take = acc_valid && acc_ready;
  wire        w16  = cfg_q[acc_req.bank] && !acc_req.byte_acc;
  wire  [2:0] need = cfg_q[7] ? dhwrc_pkg::GAP_SAME_BANK_LONG : dhwrc_pkg::GAP_SAME_BANK;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q   <= 8'h00;
      frc_q   <= 8'h00;
      cur16_q <= 1'b0;
      short_q <= 1'b0;
      row_p_q <= 4'hf;
      for (int b = 0; b < 4; b++) hi_q[b] <= 3'h7;
    end else begin
      if (wr && paddr == dhwrc_pkg::DRAM_CONFIG_ADDR) cfg_q <= pwdata[7:0] & 8'hef;
      if (wr && paddr == dhwrc_pkg::STROBE_FORCE_ADDR) frc_q <= pwdata[7:0];
      if (take) cur16_q <= cfg_q[acc_req.bank];
      else if (acc_done) cur16_q <= 1'b0;
      row_p_q <= dram_o.row_strobe_n;
      short_q <= 1'b0;
      // Forced or refresh falls are not accesses, so they are left out
      for (int b = 0; b < 4; b++) begin
        hi_q[b] <= !dram_o.row_strobe_n[b] ? 3'h0 : (hi_q[b] == 3'h7) ? 3'h7 : hi_q[b] + 3'h1;
        if (row_p_q[b] && !dram_o.row_strobe_n[b] && &dram_o.col_strobe_n && frc_q == 8'h00
            && hi_q[b] < need) short_q <= 1'b1;
      end
    end
  end
  // ----
  // Properties
  // ----
  a_force_strobes: assert property (
    (~dram_o.col_strobe_n & frc_q[7:4]) == frc_q[7:4]
    && (~dram_o.row_strobe_n & frc_q[3:0]) == frc_q[3:0]) else $error("forced strobe not low");
  a_we_rise_safe: assert property (
    $rose(dram_o.write_strobe_n) && frc_q[7:4] == 4'h0 |-> &dram_o.col_strobe_n)
    else $error("write strobe rose under column strobe");
  a_refresh_cbr: assert property (
    dram_o.row_strobe_n == 4'h0 && $past(dram_o.row_strobe_n) == 4'hf && frc_q == 8'h00
    |-> dram_o.col_strobe_n == 4'h0 && $past(dram_o.col_strobe_n) == 4'h0)
    else $error("refresh row fell before column");
  a_row_precharge: assert property (!short_q)
    else $error("row strobe precharge too short");
  a_upper_cas_idle: assert property (
    cur16_q && !acc_done && frc_q[7:6] == 2'b00 |-> dram_o.col_strobe_n[3:2] == 2'b11)
    else $error("upper column strobes used on narrow bank");
  a_word16_split: assert property (
    take && w16 && cfg_q[6:5] == 2'b00 |-> ##[6:7] acc_done) else $error("narrow word length");
  a_single_len: assert property (
    take && !w16 && cfg_q[6:5] == 2'b00 |-> ##[4:5] acc_done) else $error("single access length");
  a_gap_done: assert property (acc_done |-> !acc_ready)
    else $error("access taken at end cycle");
endmodule : dhwrc_ctrl_checker

bind dhwrc_ctrl dhwrc_ctrl_checker i_dhwrc_ctrl_checker (.pclk, .presetn, .paddr, .psel, .penable,
  .pwrite, .pwdata, .pready, .acc_valid, .acc_req, .acc_ready, .acc_done, .dram_o);

// [dv/dhwrc_dram_model.sv]
`timescale 1ns/1ns
module dhwrc_dram_model (
  // Strobes and data from the controller
  input  wire logic                   pclk,
  input  wire dhwrc_pkg::dhwrc_pins_t pins,
  input  wire logic                   edo,
  // Read data
  output logic [31:0]                 dq
);
  logic [31:0] mem [int];
  logic [16:0] log [$];
  logic [11:0] row_q;
  logic [1:0]  bank_q;
  logic [3:0]  rp_q, cp_q;
  logic        drive;
  int          key;
  initial begin
    dq = 32'h5a5a_a5a5;
    drive = 1'b0;
    key = 0;
    rp_q = 4'hf;
    cp_q = 4'hf;
  end
  // ----
  // Strobes sampled mid-cycle, away from the launching edge
  // ----
  always @(negedge pclk) begin
    if (rp_q == 4'hf && pins.row_strobe_n != 4'hf && &pins.col_strobe_n) begin
      row_q <= pins.row_col_address_bus;
      for (int b = 0; b < 4; b++) if (!pins.row_strobe_n[b]) bank_q <= 2'(b);
    end
    // Fast page output dies with the column strobe, EDO holds to row close
    if (pins.row_strobe_n == 4'hf || (!edo && &pins.col_strobe_n)) drive = 1'b0;
    if (&cp_q && !(&pins.col_strobe_n) && pins.row_strobe_n != 4'hf) begin
      key = {bank_q, row_q, pins.row_col_address_bus};
      if (!pins.write_strobe_n) begin
        for (int l = 0; l < 4; l++)
          if (!pins.col_strobe_n[l]) mem[key][l*8 +: 8] = pins.dq_o[l*8 +: 8];
        log.push_back({pins.row_col_address_bus[0], pins.dq_o[15:0]});
      end else drive = 1'b1;
    end
    rp_q <= pins.row_strobe_n;
    cp_q <= pins.col_strobe_n;
    dq <= (drive && mem.exists(key)) ? mem[key] : ~dq;
  end
endmodule : dhwrc_dram_model

// [dv/tb_dhwrc_ctrl.sv]
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb_dhwrc_ctrl;
  logic                   pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr, err;
  logic                   acc_valid, acc_ready, acc_done, fixed_reference_clock;
  logic [31:0]            paddr, pwdata, prdata, acc_rdata, dram_dq_i, rd, d;
  logic [25:0]            a;
  logic [1:0]             bk, op;
  logic [7:0]             cfg;
  logic [3:0]             row_p;
  dhwrc_pkg::dhwrc_req_t  acc_req;
  dhwrc_pkg::dhwrc_pins_t dram_o;
  logic [31:0]            shadow [int];
  logic [7:0]             cfgs [6] = '{8'h00, 8'h0f, 8'h2a, 8'h45, 8'h80, 8'hff};
  logic [3:0]             codes [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
  int                     bad_count, checks, seed, n_ref, ref_div, k, n0;
  localparam logic [31:0] RP = dhwrc_pkg::REFRESH_PERIOD_ADDR;
  localparam logic [31:0] FC = dhwrc_pkg::STROBE_FORCE_ADDR;

  dhwrc_ctrl #(.REF_TICKS_PER_US(1)) i_dhwrc_ctrl (.pclk, .presetn, .por_n, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .acc_valid, .acc_req, .acc_ready,
    .acc_done, .acc_rdata, .fixed_reference_clock, .dram_dq_i, .dram_o);
  dhwrc_dram_model i_dhwrc_dram_model (.pclk, .pins(dram_o), .edo(cfg[5]), .dq(dram_dq_i));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // ----
  // Reference clock at 1 MHz and refresh counting
  // ----
  always @(posedge pclk) begin
    ref_div <= (ref_div == 4) ? 0 : ref_div + 1;
    if (ref_div == 4) fixed_reference_clock <= ~fixed_reference_clock;
  end
  always @(negedge pclk) begin
    row_p <= dram_o.row_strobe_n;
    if (row_p == 4'hf && dram_o.row_strobe_n == 4'h0 && dram_o.col_strobe_n == 4'h0) n_ref++;
  end
  // ----
  // Bus tasks
  // ----
  task automatic apb(input logic w, input logic [31:0] ad, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, ad, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) bad_count++;
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic acc(input logic w, ab, input logic [1:0] abk, input logic [25:0] aa,
                     input logic [31:0] ad);
    int n;
    @(posedge pclk);
    acc_valid <= 1'b1;
    acc_req <= '{w, ab, abk, aa, ad};
    n = 0;
    do begin @(posedge pclk); n++; end while (acc_ready !== 1'b1 && n < 500);
    `CHK("access taken", 1'b1, acc_ready)
    acc_valid <= 1'b0;
    n = 0;
    do begin @(posedge pclk); n++; end while (acc_done !== 1'b1 && n < 50);
    `CHK("access done", 1'b1, acc_done)
    rd = acc_rdata;
  endtask : acc
  function automatic int exp_writes(input logic [1:0] o, input logic is16);
    return (o == 2'd0) ? (is16 ? 2 : 1) : (o == 2'd1) ? 1 : 0;
  endfunction : exp_writes
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  // ----
  // Scenarios
  // ----
  initial begin
    seed = 32'h8c7a;
    {psel, penable, pwrite, acc_valid, fixed_reference_clock, presetn, por_n} = '0;
    {paddr, pwdata, acc_req, ref_div, n_ref, bad_count, checks, cfg} = '0;
    row_p = 4'hf;
    repeat (12) @(posedge pclk);
    {presetn, por_n} <= 2'b11;
    apb(0, RP, 0);
    `CHK("period reset", 32'h1, rd)
    apb(0, dhwrc_pkg::DRAM_CONFIG_ADDR, 0);
    `CHK("config reset", 32'h0, rd)
    apb(0, FC, 0);
    `CHK("force reset", 32'h0, rd)
    apb(1, 32'h0320_00d8, 32'hff);
    `CHK("unmapped error", 1'b1, err)
    foreach (codes[i]) begin
      apb(1, RP, {28'h0, codes[i]});
      apb(0, RP, 0);
      `CHK("period readback", {28'h0, codes[i]}, rd)
    end
    apb(1, RP, 0);
    n_ref = 0;
    repeat (400) @(posedge pclk);
    `CHK("refresh off", 0, n_ref)
    // No access is in flight while the strobes are forced
    apb(1, FC, 32'ha5);
    apb(0, FC, 0);
    `CHK("force readback", 32'ha5, rd)
    @(negedge pclk);
    `CHK("forced rows", 4'ha, dram_o.row_strobe_n)
    `CHK("forced cols", 4'h5, dram_o.col_strobe_n)
    apb(1, FC, 0);
    apb(1, RP, 32'h2);
    n_ref = 0;
    repeat (700) @(posedge pclk);
    `CHK("refreshes at 32us", 2, n_ref)
    presetn <= 1'b0;
    n_ref = 0;
    repeat (400) @(posedge pclk);
    `CHK("refresh in reset", 1'b1, n_ref >= 2)
    presetn <= 1'b1;
    for (int c = 0; c < 6; c++) begin
      cfg = cfgs[c];
      apb(1, dhwrc_pkg::DRAM_CONFIG_ADDR, {24'h0, cfg});
      apb(0, dhwrc_pkg::DRAM_CONFIG_ADDR, 0);
      `CHK("config readback", {24'h0, cfg & 8'hef}, rd)
      shadow.delete();
      for (int i = 0; i < 14; i++) begin
        bk = 2'($random(seed));
        a = 26'($random(seed)) & 26'h0c0c3f;
        op = 2'($random(seed));
        d = $random(seed);
        k = {bk, a[25:2]};
        if (!shadow.exists(k)) op = 2'd0;
        n0 = i_dhwrc_dram_model.log.size();
        case (op)
          2'd0: begin
            acc(1, 0, bk, {a[25:2], 2'b00}, d);
            shadow[k] = d;
            if (cfg[bk]) begin
              `CHK("upper half first", {1'b0, d[31:16]}, i_dhwrc_dram_model.log[n0])
              `CHK("lower half next", {1'b1, d[15:0]}, i_dhwrc_dram_model.log[n0+1])
            end
          end
          2'd1: begin
            acc(1, 1, bk, a, {4{d[7:0]}});
            shadow[k][a[1:0]*8 +: 8] = d[7:0];
          end
          2'd2: begin
            acc(0, 0, bk, {a[25:2], 2'b00}, 0);
            `CHK("word read", shadow[k], rd)
          end
          default: begin
            acc(0, 1, bk, a, 0);
            `CHK("byte read", shadow[k][a[1:0]*8 +: 8], rd[a[1:0]*8 +: 8])
          end
        endcase
        `CHK("dram writes", exp_writes(op, cfg[bk]), i_dhwrc_dram_model.log.size() - n0)
      end
    end
    final_report();
  end
  initial begin
    #3_000_000;
    bad_count++;
    final_report();
  end
endmodule : tb_dhwrc_ctrl

// [include/dhwrc_pkg.sv]
package dhwrc_pkg;

  // ----------------------------------------
  // Register map and reset values
  // ----------------------------------------
  localparam logic [31:0] REFRESH_PERIOD_ADDR = 32'h0320_008c;
  localparam logic [31:0] DRAM_CONFIG_ADDR    = 32'h0320_00d0;
  localparam logic [31:0] STROBE_FORCE_ADDR   = 32'h0320_00d4;
  localparam logic [3:0]  REFRESH_PERIOD_RST  = 4'h1;
  localparam logic [7:0]  DRAM_CONFIG_RST     = 8'h00;
  localparam logic [7:0]  DRAM_CONFIG_MASK    = 8'hef;
  localparam logic [7:0]  STROBE_FORCE_RST    = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CFG_PRECHARGE_BIT = 7;
  localparam int CFG_RAS_CAS_BIT   = 6;
  localparam int CFG_EDO_BIT       = 5;

  // ----------------------------------------
  // Timing in memory clocks
  // ----------------------------------------
  localparam logic [2:0] GAP_OTHER_BANK     = 3'h2;
  localparam logic [2:0] GAP_SAME_BANK      = 3'h3;
  localparam logic [2:0] GAP_SAME_BANK_LONG = 3'h4;
  localparam logic [2:0] GAP_MAX            = 3'h7;
  localparam logic [1:0] RAS_CAS_CYC        = 2'h2;
  localparam logic [1:0] RAS_CAS_LONG_CYC   = 2'h3;

  // ----------------------------------------
  // Refresh periods in microseconds
  // ----------------------------------------
  localparam int REF_US_16  = 16;
  localparam int REF_US_32  = 32;
  localparam int REF_US_64  = 64;
  localparam int REF_US_128 = 128;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_RAS  = 3'b001,
    M_CAS  = 3'b010,
    M_CASH = 3'b011,
    M_TAIL = 3'b100
  } dhwrc_mst_t;

  typedef enum logic [1:0] {
    F_IDLE = 2'b00,
    F_CAS  = 2'b01,
    F_BOTH = 2'b10,
    F_RAS  = 2'b11
  } dhwrc_fst_t;

  typedef struct packed {
    logic        write;
    logic        byte_acc;
    logic [1:0]  bank;
    logic [25:0] addr;
    logic [31:0] wdata;
  } dhwrc_req_t;

  typedef struct packed {
    logic [3:0]  row_strobe_n;
    logic [3:0]  col_strobe_n;
    logic        write_strobe_n;
    logic [11:0] row_col_address_bus;
    logic [31:0] dq_o;
    logic        dq_oe;
  } dhwrc_pins_t;

  typedef struct packed {
    dhwrc_mst_t  st;
    logic [1:0]  cnt;
    logic        half;
    dhwrc_req_t  req;
    logic [2:0]  gap;
    logic [1:0]  last_bank;
    logic        last_all;
    logic [31:0] rdata;
    logic        done;
    logic [7:0]  cfg;
    logic [3:0]  period;
    logic [7:0]  force_bits;
    logic [31:0] prdata;
    dhwrc_pins_t pins;
  } dhwrc_main_t;

  typedef struct packed {
    logic [2:0]  sync;
    logic [10:0] cnt;
    logic        pend;
    dhwrc_fst_t  st;
    logic        ras_n;
    logic        cas_n;
  } dhwrc_ref_t;

endpackage : dhwrc_pkg

// [verilog/dhwrc_ctrl.sv]
`timescale 1ns/1ns
module dhwrc_ctrl #(
  parameter int REF_TICKS_PER_US = 1
) (
  // Clock and resets
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  por_n,
  // APB slave
  input  wire logic [31:0]           paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Processor and DMA access port
  input  wire logic                  acc_valid,
  input  wire dhwrc_pkg::dhwrc_req_t acc_req,
  output logic                       acc_ready,
  output logic                       acc_done,
  output logic      [31:0]           acc_rdata,
  // DRAM side
  input  wire logic                  fixed_reference_clock,
  input  wire logic [31:0]           dram_dq_i,
  output dhwrc_pkg::dhwrc_pins_t     dram_o
);

  dhwrc_pkg::dhwrc_main_t s_q;
  dhwrc_pkg::dhwrc_main_t s_d;
  logic                   ref_pend;
  logic                   ref_busy;
  logic                   ref_ras_n;
  logic                   ref_cas_n;
  logic                   ref_grant;
  logic                   period_wr;
  logic                   apb_setup;
  logic                   apb_access;
  logic [1:0]             sel;
  logic [2:0]             need;
  logic [2:0]             need_all;
  logic                   edo;
  logic                   wide16;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [1:0] reg_sel(input logic [31:0] a);
    if (a == dhwrc_pkg::REFRESH_PERIOD_ADDR) begin
      reg_sel = 2'h1;
    end else if (a == dhwrc_pkg::DRAM_CONFIG_ADDR) begin
      reg_sel = 2'h2;
    end else if (a == dhwrc_pkg::STROBE_FORCE_ADDR) begin
      reg_sel = 2'h3;
    end else begin
      reg_sel = 2'h0;
    end
  endfunction : reg_sel

  // Address mux; 16-bit banks take address bits one lower, a[25] unused
  function automatic logic [11:0] mux_addr(
    input logic [25:0] a,
    input logic        is16,
    input logic        col,
    input logic        half
  );
    if (!is16 && !col) begin
      mux_addr = {a[24], a[22], a[19:10]};
    end else if (!is16) begin
      mux_addr = {a[25], a[23], a[21], a[20], a[9:2]};
    end else if (!col) begin
      mux_addr = {a[23], a[21], a[18:9]};
    end else begin
      mux_addr = {a[24], a[22], a[20], a[19], a[8:2], half};
    end
  endfunction : mux_addr

  // Pin values for a given next state, registered afterwards
  function automatic dhwrc_pkg::dhwrc_pins_t pins_of(
    input dhwrc_pkg::dhwrc_main_t s
  );
    logic is16;
    logic wr_on;
    is16                        = s.cfg[s.req.bank];
    wr_on                       = s.req.write &&
                                  (s.st == dhwrc_pkg::M_CAS || s.st == dhwrc_pkg::M_CASH);
    pins_of.row_strobe_n        = 4'hf;
    pins_of.col_strobe_n        = 4'hf;
    pins_of.write_strobe_n      = ~wr_on;
    pins_of.row_col_address_bus = mux_addr(s.req.addr, is16, s.st != dhwrc_pkg::M_RAS, s.half);
    pins_of.dq_oe               = wr_on;
    pins_of.dq_o                = s.req.wdata;
    if (is16) begin
      pins_of.dq_o = {16'h0000, s.half ? s.req.wdata[15:0] : s.req.wdata[31:16]};
    end
    if (s.st != dhwrc_pkg::M_IDLE) begin
      pins_of.row_strobe_n[s.req.bank] = 1'b0;
    end
    if (s.st == dhwrc_pkg::M_CAS) begin
      if (is16 && s.req.byte_acc) begin
        pins_of.col_strobe_n[s.req.addr[0]] = 1'b0;
      end else if (is16) begin
        pins_of.col_strobe_n = 4'hc;
      end else if (s.req.byte_acc) begin
        pins_of.col_strobe_n[s.req.addr[1:0]] = 1'b0;
      end else begin
        pins_of.col_strobe_n = 4'h0;
      end
    end
  endfunction : pins_of

  // Latch one read beat into its half of the word
  function automatic logic [31:0] latch(
    input logic [31:0] old,
    input logic [31:0] dq,
    input logic        is16,
    input logic        half
  );
    latch = dq;
    if (is16 && !half) begin
      latch = {dq[15:0], old[15:0]};
    end else if (is16) begin
      latch = {old[31:16], dq[15:0]};
    end
  endfunction : latch

  // ----------------------------------------
  // Refresh timer and sequencer
  // ----------------------------------------
  dhwrc_refresh #(
    .REF_TICKS_PER_US (REF_TICKS_PER_US)
  ) u_refresh (
    .pclk                  (pclk),
    .por_n                 (por_n),
    .fixed_reference_clock (fixed_reference_clock),
    .period                (s_q.period),
    .period_wr             (period_wr),
    .grant                 (ref_grant),
    .pend                  (ref_pend),
    .busy                  (ref_busy),
    .ras_n                 (ref_ras_n),
    .cas_n                 (ref_cas_n)
  );

  // ----------------------------------------
  // Decode and precharge checks
  // ----------------------------------------
  assign apb_setup  = psel & ~penable;
  assign apb_access = psel & penable;
  assign sel        = reg_sel(paddr);
  assign period_wr  = apb_access & pwrite & (sel == 2'h1) & (pwdata[3:0] != 4'h0);
  assign edo        = s_q.cfg[dhwrc_pkg::CFG_EDO_BIT];
  assign wide16     = s_q.cfg[s_q.req.bank];

  assign need_all = s_q.cfg[dhwrc_pkg::CFG_PRECHARGE_BIT] ?
                    dhwrc_pkg::GAP_SAME_BANK_LONG : dhwrc_pkg::GAP_SAME_BANK;
  assign need     = (s_q.last_all || acc_req.bank == s_q.last_bank) ?
                    need_all : dhwrc_pkg::GAP_OTHER_BANK;

  // Refresh goes first once the bus is idle and rows have precharged
  // In reset the sequencer is parked idle, so refresh must not wait on the gap
  assign ref_grant = (s_q.st == dhwrc_pkg::M_IDLE) & ref_pend & ~ref_busy &
                     (~presetn | (s_q.gap >= need_all));
  assign acc_ready = (s_q.st == dhwrc_pkg::M_IDLE) & ~ref_pend & ~ref_busy &
                     (s_q.gap >= need);

  // ----------------------------------------
  // Registers and access sequencer
  // ----------------------------------------
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;

    if (apb_access && pwrite) begin
      if (sel == 2'h1) begin
        s_d.period = pwdata[3:0];
      end else if (sel == 2'h2) begin
        s_d.cfg = pwdata[7:0] & dhwrc_pkg::DRAM_CONFIG_MASK;
      end else if (sel == 2'h3) begin
        s_d.force_bits = pwdata[7:0];
      end
    end
    if (apb_setup) begin
      if (sel == 2'h1) begin
        s_d.prdata = {28'h0000000, s_q.period};
      end else if (sel == 2'h2) begin
        s_d.prdata = {24'h000000, s_q.cfg};
      end else if (sel == 2'h3) begin
        s_d.prdata = {24'h000000, s_q.force_bits};
      end else begin
        s_d.prdata = 32'h00000000;
      end
    end

    // Cycles of row strobe high, saturating
    if (ref_busy) begin
      s_d.gap      = 3'h1;
      s_d.last_all = 1'b1;
    end else if (s_q.gap != dhwrc_pkg::GAP_MAX) begin
      s_d.gap = s_q.gap + 3'h1;
    end

    case (s_q.st)
      dhwrc_pkg::M_IDLE: begin
        if (acc_valid && acc_ready) begin
          s_d.req = acc_req;
          s_d.st  = dhwrc_pkg::M_RAS;
          s_d.cnt = 2'h1;
          // Byte in a 16-bit bank: upper bytes sit at the lower location
          s_d.half = s_q.cfg[acc_req.bank] & acc_req.byte_acc & ~acc_req.addr[1];
        end
      end
      dhwrc_pkg::M_RAS: begin
        if (s_q.cnt >= (s_q.cfg[dhwrc_pkg::CFG_RAS_CAS_BIT] ?
                        dhwrc_pkg::RAS_CAS_LONG_CYC : dhwrc_pkg::RAS_CAS_CYC)) begin
          s_d.st = dhwrc_pkg::M_CAS;
        end else begin
          s_d.cnt = s_q.cnt + 2'h1;
        end
      end
      dhwrc_pkg::M_CAS: begin
        s_d.st = dhwrc_pkg::M_CASH;
        if (!s_q.req.write && !edo) begin
          s_d.rdata = latch(s_q.rdata, dram_dq_i, wide16, s_q.half);
        end
      end
      dhwrc_pkg::M_CASH: begin
        if (!s_q.req.write && edo) begin
          s_d.rdata = latch(s_q.rdata, dram_dq_i, wide16, s_q.half);
        end
        if (wide16 && !s_q.req.byte_acc && !s_q.half) begin
          s_d.half = 1'b1;
          s_d.st   = dhwrc_pkg::M_CAS;
        end else if (edo) begin
          s_d.st = dhwrc_pkg::M_TAIL;
        end else begin
          s_d.st        = dhwrc_pkg::M_IDLE;
          s_d.done      = 1'b1;
          s_d.gap       = 3'h1;
          s_d.last_bank = s_q.req.bank;
          s_d.last_all  = 1'b0;
        end
      end
      default: begin
        s_d.st        = dhwrc_pkg::M_IDLE;
        s_d.done      = 1'b1;
        s_d.gap       = 3'h1;
        s_d.last_bank = s_q.req.bank;
        s_d.last_all  = 1'b0;
      end
    endcase

    s_d.pins = pins_of(s_d);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{st: dhwrc_pkg::M_IDLE, cnt: 2'h0, half: 1'b0, req: '0, gap: 3'h0,
               last_bank: 2'h0, last_all: 1'b1, rdata: 32'h00000000, done: 1'b0,
               cfg: dhwrc_pkg::DRAM_CONFIG_RST, period: dhwrc_pkg::REFRESH_PERIOD_RST,
               force_bits: dhwrc_pkg::STROBE_FORCE_RST, prdata: 32'h00000000,
               pins: '{row_strobe_n: 4'hf, col_strobe_n: 4'hf, write_strobe_n: 1'b1,
                       row_col_address_bus: 12'h000, dq_o: 32'h00000000, dq_oe: 1'b0}};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata    = s_q.prdata;
  assign pready    = 1'b1;
  assign pslverr   = apb_access & (sel == 2'h0);
  assign acc_done  = s_q.done;
  assign acc_rdata = s_q.rdata;

  // Forcing is combinational so it acts at once, even mid-cycle
  always_comb begin
    dram_o = s_q.pins;
    if (ref_busy) begin
      dram_o.row_strobe_n   = {4{ref_ras_n}};
      dram_o.col_strobe_n   = {4{ref_cas_n}};
      dram_o.write_strobe_n = 1'b1;
      dram_o.dq_oe          = 1'b0;
    end
    dram_o.row_strobe_n = dram_o.row_strobe_n & ~s_q.force_bits[3:0];
    dram_o.col_strobe_n = dram_o.col_strobe_n & ~s_q.force_bits[7:4];
  end

endmodule : dhwrc_ctrl

// [verilog/dhwrc_refresh.sv]
`timescale 1ns/1ns
module dhwrc_refresh #(
  parameter int REF_TICKS_PER_US = 1
) (
  // Clock and power-on reset
  input  wire logic       pclk,
  input  wire logic       por_n,
  // Reference clock pin
  input  wire logic       fixed_reference_clock,
  // Control
  input  wire logic [3:0] period,
  input  wire logic       period_wr,
  input  wire logic       grant,
  // Status and strobes
  output logic            pend,
  output logic            busy,
  output logic            ras_n,
  output logic            cas_n
);

  dhwrc_pkg::dhwrc_ref_t r_q;
  dhwrc_pkg::dhwrc_ref_t r_d;
  logic                  tick;
  logic [10:0]           target;

  // ----------------------------------------
  // Period decode
  // ----------------------------------------
  // Undefined codes are treated as off rather than guessed
  function automatic logic [10:0] ticks(input logic [3:0] p);
    case (p)
      4'h1:    ticks = 11'(dhwrc_pkg::REF_US_16 * REF_TICKS_PER_US);
      4'h2:    ticks = 11'(dhwrc_pkg::REF_US_32 * REF_TICKS_PER_US);
      4'h4:    ticks = 11'(dhwrc_pkg::REF_US_64 * REF_TICKS_PER_US);
      4'h8:    ticks = 11'(dhwrc_pkg::REF_US_128 * REF_TICKS_PER_US);
      default: ticks = 11'h000;
    endcase
  endfunction : ticks

  assign target = ticks(period);
  assign tick   = r_q.sync[1] & ~r_q.sync[2];
  assign pend   = r_q.pend;
  assign busy   = (r_q.st != dhwrc_pkg::F_IDLE);
  assign ras_n  = r_q.ras_n;
  assign cas_n  = r_q.cas_n;

  // ----------------------------------------
  // Timer and sequencer
  // ----------------------------------------
  always_comb begin
    r_d      = r_q;
    r_d.sync = {r_q.sync[1:0], fixed_reference_clock};
    case (r_q.st)
      dhwrc_pkg::F_IDLE: begin
        if (grant) begin
          r_d.st   = dhwrc_pkg::F_CAS;
          r_d.pend = 1'b0;
        end
      end
      dhwrc_pkg::F_CAS:  r_d.st = dhwrc_pkg::F_BOTH;
      dhwrc_pkg::F_BOTH: r_d.st = dhwrc_pkg::F_RAS;
      default:           r_d.st = dhwrc_pkg::F_IDLE;
    endcase
    // A new expiry in the grant cycle wins over the clear
    if (target == 11'h000 || period_wr) begin
      r_d.cnt = 11'h000;
    end else if (tick) begin
      if (r_q.cnt + 11'h001 >= target) begin
        r_d.cnt  = 11'h000;
        r_d.pend = 1'b1;
      end else begin
        r_d.cnt = r_q.cnt + 11'h001;
      end
    end
    r_d.cas_n = ~(r_d.st == dhwrc_pkg::F_CAS || r_d.st == dhwrc_pkg::F_BOTH);
    r_d.ras_n = ~(r_d.st == dhwrc_pkg::F_BOTH || r_d.st == dhwrc_pkg::F_RAS);
  end

  // Power-on reset only, so refresh keeps going while presetn is low
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      r_q <= '{sync: 3'h0, cnt: 11'h000, pend: 1'b0, st: dhwrc_pkg::F_IDLE,
               ras_n: 1'b1, cas_n: 1'b1};
    end else begin
      r_q <= r_d;
    end
  end

endmodule : dhwrc_refresh
